/* dpi_pkg.sv */
package dpi_pkg;
  localparam int DW = 8;
  localparam int NUM_SIDES = 2;
  localparam int SIDE_A = 0;
  localparam int SIDE_B = 1;
  // Register-select addresses
  localparam logic [1:0] ADDR_PORT_A = 2'h0;
  localparam logic [1:0] ADDR_CTL_A = 2'h1;
  localparam logic [1:0] ADDR_PORT_B = 2'h2;
  localparam logic [1:0] ADDR_CTL_B = 2'h3;
  // Control register bit positions
  localparam int CTL_IN1_EN = 0;
  localparam int CTL_IN1_POS = 1;
  localparam int CTL_PORT_SEL = 2;
  localparam int CTL_L2_CTRL = 3;
  localparam int CTL_L2_POS = 4;
  localparam int CTL_L2_OUT = 5;
  localparam int CTL_FLAG2 = 6;
  localparam int CTL_FLAG1 = 7;
  // Only bits 5..0 are writable; flags are hardware owned
  localparam int CTL_WR_TOP = 5;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [7:0] ALL_IN = 8'h00;

  typedef enum logic [1:0] {
    DPI_L2_INPUT = 2'b00,
    DPI_L2_STROBE = 2'b01,
    DPI_L2_MANUAL = 2'b10
  } dpi_l2_mode_t;

  typedef struct packed {
    logic ph2;
    logic sel_hi0;
    logic sel_hi1;
    logic sel_lo2;
    logic [1:0] reg_sel;
    logic rd_nwr;
    logic [DW-1:0] data;
    logic init_n;
    logic [NUM_SIDES-1:0] in1;
    logic [NUM_SIDES-1:0] line2;
    logic [DW-1:0] pa;
    logic [DW-1:0] pb;
  } dpi_pins_t;

  typedef struct packed {
    logic sel;
    logic [1:0] addr;
    logic rd;
    logic [DW-1:0] data;
  } dpi_snap_t;

  typedef struct packed {
    logic [7:0] ctl;
    logic [DW-1:0] dir;
    logic [DW-1:0] outr;
    logic in1_q;
    logic l2_q;
    logic l2_low;
  } dpi_side_t;

  typedef struct packed {
    dpi_pins_t sync1;
    dpi_pins_t sync2;
    logic ph2_q;
    dpi_snap_t snap;
    logic [DW-1:0] rdata;
    logic rd_oe;
    dpi_side_t [NUM_SIDES-1:0] side;
  } dpi_state_t;
endpackage

/* dpi_port_adapter.sv */
// Contract
// - Bus access only while select zero and one high and select two low.
// - Initialise low clears control, direction and output registers.
// - Read-not-write high reads toward processor, low writes into device.
// - Two select lines address port A, control A, port B, control B.
// - Control bit 2 picks pins/output register or direction register.
// - Control, direction, output registers writable; control, direction readable.
// - Per-side interrupt request is active low, open drain.
// - Control bits 6 and 7 hold the interrupt flags.
// - Bit 7 set by any active A1 edge; bit 0 only gates request.
// - Bit 6 set by A2 edge in input mode; bit 3 gates it.
// - Reading port A pins clears control A bits 6 and 7.
// - Request low while (bit7 and bit0) or (bit6 and bit3).
// - Side B mirrors side A flags, edges and gating.
// - Reading port B pins clears control B bits 6 and 7.
// - A1 is input only; bit 1 selects falling or rising edge.
// - Bit 5 zero makes A2 input; bit 4 chooses its edge.
// - Bits 5,4,3 = 1,0,1: A2 pulses once per port A pin read.
// - Port B input lines are high impedance.
// - Eight-bit tri-state data bus, released unless driving read data.
// - Direction bit 1 drives output register bit; 0 makes input.
// - Write data lands in register after phase-two trailing edge.
// - Manual output mode: A2 follows control bit 3.
// - Strobe: low after read; back high on next fall or A1 edge.
`timescale 1ns/1ps
`default_nettype none
module dpi_port_adapter #(
  parameter int DATA_W = dpi_pkg::DW
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_ph2,
  input wire logic i_select_high_zero,
  input wire logic i_select_high_one,
  input wire logic i_select_low_two,
  input wire logic i_reg_sel_lo,
  input wire logic i_reg_sel_hi,
  input wire logic i_rd_nwr,
  input wire logic i_init_n,
  input wire logic [DATA_W-1:0] i_bus_buffer,
  output logic [DATA_W-1:0] o_bus_buffer,
  output logic o_bus_buffer_oe,
  output logic o_side_a_int_n,
  output logic o_side_a_int_n_oe,
  output logic o_side_b_int_n,
  output logic o_side_b_int_n_oe,
  input wire logic i_ctl_a_in1,
  input wire logic i_ctl_b_in1,
  input wire logic i_ctl_a_line2,
  output logic o_ctl_a_line2,
  output logic o_ctl_a_line2_oe,
  input wire logic i_ctl_b_line2,
  output logic o_ctl_b_line2,
  output logic o_ctl_b_line2_oe,
  input wire logic [DATA_W-1:0] i_port_a_lines,
  output logic [DATA_W-1:0] o_port_a_lines,
  output logic [DATA_W-1:0] o_port_a_lines_oe,
  input wire logic [DATA_W-1:0] i_port_b_lines,
  output logic [DATA_W-1:0] o_port_b_lines,
  output logic [DATA_W-1:0] o_port_b_lines_oe
);
  localparam int NS = dpi_pkg::NUM_SIDES;

  // The register map is byte wide by construction
  if (DATA_W != dpi_pkg::DW) begin : g_bad_width
    $error("DATA_W must be 8");
  end

  dpi_pkg::dpi_state_t s_r;
  dpi_pkg::dpi_state_t s_nxt;
  dpi_pkg::dpi_pins_t pins;
  dpi_pkg::dpi_pins_t p;
  logic sel_now;
  logic ph2_fall;
  logic wr_ev;
  logic rd_ev;
  logic [DATA_W-1:0] rd_mux;
  logic [NS-1:0] port_addr;
  logic [NS-1:0] ctl_addr;
  logic [NS-1:0] pin_rd;
  logic [NS-1:0] in1_edge;
  logic [NS-1:0] l2_edge;
  logic [NS-1:0] irq;
  logic [DATA_W-1:0] pin_val [NS];
  logic [DATA_W-1:0] port_rd [NS];
  dpi_pkg::dpi_l2_mode_t mode [NS];

  // Every pin from the processor or peripheral enters through two flops
  assign pins = '{ph2: i_ph2, sel_hi0: i_select_high_zero,
                  sel_hi1: i_select_high_one, sel_lo2: i_select_low_two,
                  reg_sel: {i_reg_sel_hi, i_reg_sel_lo}, rd_nwr: i_rd_nwr,
                  data: i_bus_buffer, init_n: i_init_n,
                  in1: {i_ctl_b_in1, i_ctl_a_in1},
                  line2: {i_ctl_b_line2, i_ctl_a_line2},
                  pa: i_port_a_lines, pb: i_port_b_lines};
  assign p = s_r.sync2;

  // Bus decode on synchronised pins; accesses act on the trailing edge
  assign sel_now = p.sel_hi0 & p.sel_hi1 & ~p.sel_lo2;
  assign ph2_fall = s_r.ph2_q & ~p.ph2;
  assign wr_ev = ph2_fall & s_r.snap.sel & ~s_r.snap.rd;
  assign rd_ev = ph2_fall & s_r.snap.sel & s_r.snap.rd;

  // Per-side decode, edge detect and interrupt request
  for (genvar i = 0; i < NS; i++) begin : g_side
    localparam logic [1:0] PADDR = (i == 0) ? dpi_pkg::ADDR_PORT_A : dpi_pkg::ADDR_PORT_B;
    localparam logic [1:0] CADDR = (i == 0) ? dpi_pkg::ADDR_CTL_A : dpi_pkg::ADDR_CTL_B;
    logic [7:0] c;
    logic in1_now;
    logic l2_now;
    assign c = s_r.side[i].ctl;
    assign in1_now = p.in1[i];
    assign l2_now = p.line2[i];
    assign pin_val[i] = (i == 0) ? p.pa : p.pb;
    assign port_addr[i] = s_r.snap.addr == PADDR;
    assign ctl_addr[i] = s_r.snap.addr == CADDR;
    assign port_rd[i] = c[dpi_pkg::CTL_PORT_SEL] ? pin_val[i] : s_r.side[i].dir;
    assign pin_rd[i] = rd_ev & port_addr[i] & c[dpi_pkg::CTL_PORT_SEL];
    // Compare against the sample from the previous phase-two fall
    assign in1_edge[i] = ph2_fall & (c[dpi_pkg::CTL_IN1_POS] ? (~s_r.side[i].in1_q & in1_now)
                                                             : (s_r.side[i].in1_q & ~in1_now));
    assign l2_edge[i] = ph2_fall & ~c[dpi_pkg::CTL_L2_OUT] &
                        (c[dpi_pkg::CTL_L2_POS] ? (~s_r.side[i].l2_q & l2_now)
                                                : (s_r.side[i].l2_q & ~l2_now));
    assign mode[i] = ~c[dpi_pkg::CTL_L2_OUT] ? dpi_pkg::DPI_L2_INPUT :
                     c[dpi_pkg::CTL_L2_POS] ? dpi_pkg::DPI_L2_MANUAL : dpi_pkg::DPI_L2_STROBE;
    // Flag and its enable, either pair pulls the request
    assign irq[i] = (c[dpi_pkg::CTL_FLAG1] & c[dpi_pkg::CTL_IN1_EN]) |
                    (c[dpi_pkg::CTL_FLAG2] & c[dpi_pkg::CTL_L2_CTRL]);
  end

  // Read data source follows the live register-select lines
  always_comb begin
    case (p.reg_sel)
      dpi_pkg::ADDR_PORT_A: rd_mux = port_rd[dpi_pkg::SIDE_A];
      dpi_pkg::ADDR_CTL_A: rd_mux = s_r.side[dpi_pkg::SIDE_A].ctl;
      dpi_pkg::ADDR_PORT_B: rd_mux = port_rd[dpi_pkg::SIDE_B];
      dpi_pkg::ADDR_CTL_B: rd_mux = s_r.side[dpi_pkg::SIDE_B].ctl;
      default: rd_mux = '0;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = pins;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.ph2_q = p.ph2;
    // Snapshot keeps the last value seen while phase two was high
    if (p.ph2) begin
      s_nxt.snap = '{sel: sel_now, addr: p.reg_sel, rd: p.rd_nwr, data: p.data};
    end
    s_nxt.rd_oe = p.ph2 & sel_now & p.rd_nwr;
    if (p.ph2 & sel_now & p.rd_nwr) begin
      s_nxt.rdata = rd_mux;
    end
    for (int i = 0; i < NS; i++) begin
      if (ph2_fall) begin
        s_nxt.side[i].in1_q = p.in1[i];
        s_nxt.side[i].l2_q = p.line2[i];
      end
      if (wr_ev & ctl_addr[i]) begin
        s_nxt.side[i].ctl[dpi_pkg::CTL_WR_TOP:0] = s_r.snap.data[dpi_pkg::CTL_WR_TOP:0];
      end
      if (wr_ev & port_addr[i] & s_r.side[i].ctl[dpi_pkg::CTL_PORT_SEL]) begin
        s_nxt.side[i].outr = s_r.snap.data;
      end
      if (wr_ev & port_addr[i] & ~s_r.side[i].ctl[dpi_pkg::CTL_PORT_SEL]) begin
        s_nxt.side[i].dir = s_r.snap.data;
      end
      // A new edge beats a clear in the same cycle
      s_nxt.side[i].ctl[dpi_pkg::CTL_FLAG1] =
        (s_r.side[i].ctl[dpi_pkg::CTL_FLAG1] & ~pin_rd[i]) | in1_edge[i];
      s_nxt.side[i].ctl[dpi_pkg::CTL_FLAG2] =
        ((s_r.side[i].ctl[dpi_pkg::CTL_FLAG2] & ~pin_rd[i]) | l2_edge[i]) &
        ~s_nxt.side[i].ctl[dpi_pkg::CTL_L2_OUT];
      // Line-two drive; output level stored inverted so reset means high
      case (mode[i])
        dpi_pkg::DPI_L2_MANUAL: begin
          s_nxt.side[i].l2_low = ~s_r.side[i].ctl[dpi_pkg::CTL_L2_CTRL];
        end
        dpi_pkg::DPI_L2_STROBE: begin
          if (pin_rd[i]) begin
            s_nxt.side[i].l2_low = 1'b1;
          end else if (s_r.side[i].l2_low &
                       (s_r.side[i].ctl[dpi_pkg::CTL_L2_CTRL] ? ph2_fall : in1_edge[i])) begin
            s_nxt.side[i].l2_low = 1'b0;
          end
        end
        default: begin
          s_nxt.side[i].l2_low = 1'b0;
        end
      endcase
    end
    // Initialise pin clears every programmable register
    if (~p.init_n) begin
      for (int i = 0; i < NS; i++) begin
        s_nxt.side[i].ctl = dpi_pkg::CTL_RST;
        s_nxt.side[i].dir = dpi_pkg::DIR_RST;
        s_nxt.side[i].outr = dpi_pkg::OUT_RST;
        s_nxt.side[i].l2_low = 1'b0;
      end
      s_nxt.rd_oe = 1'b0;
    end
  end

  // Single state register, constant under asynchronous reset
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Bus and open-drain request outputs
  assign o_bus_buffer = s_r.rdata;
  assign o_bus_buffer_oe = s_r.rd_oe;
  assign o_side_a_int_n = 1'b0;
  assign o_side_a_int_n_oe = irq[dpi_pkg::SIDE_A];
  assign o_side_b_int_n = 1'b0;
  assign o_side_b_int_n_oe = irq[dpi_pkg::SIDE_B];

  // Peripheral side; direction register is the per-line enable
  assign o_port_a_lines = s_r.side[dpi_pkg::SIDE_A].outr;
  assign o_port_a_lines_oe = s_r.side[dpi_pkg::SIDE_A].dir;
  assign o_port_b_lines = s_r.side[dpi_pkg::SIDE_B].outr;
  assign o_port_b_lines_oe = s_r.side[dpi_pkg::SIDE_B].dir;
  assign o_ctl_a_line2 = ~s_r.side[dpi_pkg::SIDE_A].l2_low;
  assign o_ctl_a_line2_oe = s_r.side[dpi_pkg::SIDE_A].ctl[dpi_pkg::CTL_L2_OUT];
  assign o_ctl_b_line2 = ~s_r.side[dpi_pkg::SIDE_B].l2_low;
  assign o_ctl_b_line2_oe = s_r.side[dpi_pkg::SIDE_B].ctl[dpi_pkg::CTL_L2_OUT];

  // Checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  logic [7:0] ca;
  assign ca = s_r.side[dpi_pkg::SIDE_A].ctl;

  property p_drive_only_selected;
    o_bus_buffer_oe |-> $past(sel_now) && $past(p.rd_nwr) && $past(p.ph2);
  endproperty
  a_drive_only_selected: assert property (p_drive_only_selected)
    else $error("data bus driven without a selected read");

  property p_init_clears;
    !p.init_n |=> (s_r.side[0].ctl == 8'h00) && (s_r.side[1].dir == 8'h00)
                  && (o_port_a_lines == 8'h00) && !o_bus_buffer_oe;
  endproperty
  a_init_clears: assert property (p_init_clears)
    else $error("initialise did not clear registers");

  property p_ctl_write;
    (wr_ev && ctl_addr[0] && p.init_n) |=> (ca[5:0] == $past(s_r.snap.data[5:0]));
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("control write not stored after trailing edge");

  property p_no_write_before_fall;
    (!ph2_fall && p.init_n) |=> (s_r.side[1].outr == $past(s_r.side[1].outr));
  endproperty
  a_no_write_before_fall: assert property (p_no_write_before_fall)
    else $error("output register changed outside a trailing edge");

  property p_flag_set;
    (in1_edge[0] && p.init_n) |=> ca[7];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("active edge did not set flag");

  property p_flag_clear;
    (pin_rd[0] && !in1_edge[0] && !l2_edge[0]) |=> !ca[7] && !ca[6];
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("pin read did not clear flags");

  property p_irq_a;
    (ca[7] && ca[0]) || (ca[6] && ca[3]) |-> o_side_a_int_n_oe && !o_side_a_int_n;
  endproperty
  a_irq_a: assert property (p_irq_a)
    else $error("request not asserted for enabled flag");

  property p_irq_quiet;
    !(ca[7] && ca[0]) && !(ca[6] && ca[3]) |-> !o_side_a_int_n_oe;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("request asserted while disabled");

  property p_strobe;
    (pin_rd[0] && p.init_n && ca[5:3] == 3'h5) |=> !o_ctl_a_line2;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("strobe not issued on pin read");

  property p_manual;
    (ca[5:4] == 2'h3 && p.init_n) ##1 (ca[5:4] == 2'h3) |-> o_ctl_a_line2 == $past(ca[3]);
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual line two not following bit 3");

  property p_b_hiz;
    (s_r.side[1].dir == 8'h00) |-> (o_port_b_lines_oe == 8'h00);
  endproperty
  a_b_hiz: assert property (p_b_hiz)
    else $error("port B driving while input");

  // Writes to control A at the same fall may switch to output mode and drop the flag
  property p_flag2_set;
    (l2_edge[0] && p.init_n && !(wr_ev && ctl_addr[0])) |=> ca[6];
  endproperty
  a_flag2_set: assert property (p_flag2_set)
    else $error("line two edge did not set flag");

  property p_flag_set_b;
    (in1_edge[1] && p.init_n) |=> s_r.side[1].ctl[7];
  endproperty
  a_flag_set_b: assert property (p_flag_set_b)
    else $error("side B edge did not set flag");

  property p_flag_clear_b;
    (pin_rd[1] && !in1_edge[1] && !l2_edge[1]) |=> !s_r.side[1].ctl[7] && !s_r.side[1].ctl[6];
  endproperty
  a_flag_clear_b: assert property (p_flag_clear_b)
    else $error("port B pin read did not clear flags");

  property p_flag2_out_zero;
    ca[5] |-> !ca[6];
  endproperty
  a_flag2_out_zero: assert property (p_flag2_out_zero)
    else $error("flag two set in output mode");

  property p_restore;
    (s_r.side[0].l2_low && ca[5:3] == 3'h5 && ph2_fall && !pin_rd[0] && p.init_n) |=> o_ctl_a_line2;
  endproperty
  a_restore: assert property (p_restore)
    else $error("strobe not restored at phase-two fall");

  c_ctl_write: cover property (wr_ev && ctl_addr[0]);
  c_pin_read: cover property (pin_rd[1]);
  c_strobe: cover property (pin_rd[0] && ca[5:3] == 3'h5 ##[1:20] o_ctl_a_line2);
  c_irq: cover property (o_side_b_int_n_oe);
endmodule
`default_nettype wire

/* dpi_periph_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Far-side peripheral: its own drive shows only where the adapter lets go
module dpi_periph_model (
  input wire logic [7:0] i_pa_out,
  input wire logic [7:0] i_pa_oe,
  input wire logic [7:0] i_pa_ext,
  input wire logic [7:0] i_pb_out,
  input wire logic [7:0] i_pb_oe,
  input wire logic [7:0] i_pb_ext,
  input wire logic [1:0] i_l2_out,
  input wire logic [1:0] i_l2_oe,
  input wire logic [1:0] i_l2_ext,
  output logic [7:0] o_pa,
  output logic [7:0] o_pb,
  output logic [1:0] o_l2
);
  // Wire levels: a driven bit wins, a released bit takes the peripheral level
  assign o_pa = (i_pa_out & i_pa_oe) | (~i_pa_oe & i_pa_ext);
  assign o_pb = (i_pb_out & i_pb_oe) | (~i_pb_oe & i_pb_ext);
  assign o_l2 = (i_l2_out & i_l2_oe) | (~i_l2_oe & i_l2_ext);
endmodule
`default_nettype wire

/* tb_dual_port_parallel_interface.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_dual_port_parallel_interface;
  typedef struct packed {
    logic [1:0] a;
    logic r;
    logic [7:0] d;
  } dpi_row_t;
  logic clk = 1'b0, rst_b = 1'b0, ph2 = 1'b0, s0 = 1'b0, s1 = 1'b0, s2 = 1'b1;
  logic rs_lo = 1'b0, rs_hi = 1'b0, rd = 1'b1, init_n = 1'b1, a1 = 1'b0, b1 = 1'b0;
  logic [7:0] dbus = 8'h00, pa_ext = 8'hFF, pb_ext = 8'h5A, pa, pb, v, dout;
  logic [7:0] pa_out, pa_oe, pb_out, pb_oe;
  logic [1:0] l2_ext = 2'h1, l2_out, l2_oe, l2;
  logic dout_oe, oe_seen, a_int, a_int_oe, b_int, b_int_oe;
  int error_cnt = 0, cmp_count = 0;
  // Plain accesses; a read row expects its data field back
  dpi_row_t rows[16] = '{'{2'h1, 1'b1, 8'h00}, '{2'h3, 1'b1, 8'h00}, '{2'h0, 1'b1, 8'h00},
    '{2'h2, 1'b1, 8'h00}, '{2'h0, 1'b0, 8'hA5}, '{2'h0, 1'b1, 8'hA5}, '{2'h1, 1'b0, 8'h04},
    '{2'h1, 1'b1, 8'h04}, '{2'h0, 1'b0, 8'h3C}, '{2'h0, 1'b1, 8'h7E}, '{2'h2, 1'b0, 8'h0F},
    '{2'h2, 1'b1, 8'h0F}, '{2'h3, 1'b0, 8'hC4}, '{2'h3, 1'b1, 8'h04}, '{2'h2, 1'b0, 8'h81},
    '{2'h2, 1'b1, 8'h51}};

  always #2 clk = ~clk;

  dpi_port_adapter dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_ph2(ph2), .i_select_high_zero(s0),
    .i_select_high_one(s1), .i_select_low_two(s2), .i_reg_sel_lo(rs_lo), .i_reg_sel_hi(rs_hi),
    .i_rd_nwr(rd), .i_init_n(init_n), .i_bus_buffer(dbus), .o_bus_buffer(dout),
    .o_bus_buffer_oe(dout_oe), .o_side_a_int_n(a_int), .o_side_a_int_n_oe(a_int_oe),
    .o_side_b_int_n(b_int), .o_side_b_int_n_oe(b_int_oe), .i_ctl_a_in1(a1), .i_ctl_b_in1(b1),
    .i_ctl_a_line2(l2[0]), .o_ctl_a_line2(l2_out[0]), .o_ctl_a_line2_oe(l2_oe[0]),
    .i_ctl_b_line2(l2[1]), .o_ctl_b_line2(l2_out[1]), .o_ctl_b_line2_oe(l2_oe[1]),
    .i_port_a_lines(pa), .o_port_a_lines(pa_out), .o_port_a_lines_oe(pa_oe),
    .i_port_b_lines(pb), .o_port_b_lines(pb_out), .o_port_b_lines_oe(pb_oe));

  dpi_periph_model periph (.i_pa_out(pa_out), .i_pa_oe(pa_oe), .i_pa_ext(pa_ext), .i_pb_out(pb_out),
    .i_pb_oe(pb_oe), .i_pb_ext(pb_ext), .i_l2_out(l2_out), .i_l2_oe(l2_oe), .i_l2_ext(l2_ext),
    .o_pa(pa), .o_pb(pb), .o_l2(l2));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One access per phase-two pulse; bus inputs held for the whole pulse
  task automatic acc(input logic sel, input logic [1:0] a, input logic r, input logic [7:0] wd,
                     output logic [7:0] rdat);
    @(posedge clk);
    ph2 <= 1'b1;
    s0 <= 1'b1;
    s1 <= 1'b1;
    s2 <= ~sel;
    {rs_hi, rs_lo} <= a;
    rd <= r;
    dbus <= r ? ~dbus : wd;
    repeat (8) @(posedge clk);
    #1 rdat = dout;
    oe_seen = dout_oe;
    @(posedge clk);
    ph2 <= 1'b0;
    repeat (4) @(posedge clk);
    s2 <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    #1 check({5'h00, l2_out[0], dout_oe, pa_oe[0]}, 8'h04);
    foreach (rows[i]) begin
      acc(1'b1, rows[i].a, rows[i].r, rows[i].d, v);
      if (rows[i].r) check(v, rows[i].d);
    end
    check(pa_oe, 8'hA5);
    check(pa_out, 8'h3C);
    check(pb_oe, 8'h0F);
    check(pb_out, 8'h81);
    // Deselected write must not land, deselected read must not drive
    acc(1'b0, 2'h1, 1'b0, 8'hFF, v);
    acc(1'b0, 2'h1, 1'b1, 8'h00, v);
    check({7'h00, oe_seen}, 8'h00);
    acc(1'b1, 2'h1, 1'b1, 8'h00, v);
    check(v, 8'h04);
    // Rising in1 edge sets flag one and pulls request A
    acc(1'b1, 2'h1, 1'b0, 8'h07, v);
    @(posedge clk) a1 <= 1'b1;
    acc(1'b1, 2'h1, 1'b1, 8'h00, v);
    check({6'h00, a_int, a_int_oe}, 8'h01);
    acc(1'b1, 2'h1, 1'b1, 8'h00, v);
    check(v, 8'h87);
    acc(1'b1, 2'h1, 1'b0, 8'h06, v);
    check({7'h00, a_int_oe}, 8'h00);
    acc(1'b1, 2'h0, 1'b1, 8'h00, v);
    acc(1'b1, 2'h1, 1'b1, 8'h00, v);
    check(v, 8'h06);
    // Falling edge polarity
    acc(1'b1, 2'h1, 1'b0, 8'h05, v);
    @(posedge clk) a1 <= 1'b0;
    acc(1'b1, 2'h1, 1'b1, 8'h00, v);
    acc(1'b1, 2'h1, 1'b1, 8'h00, v);
    check(v, 8'h85);
    // Line two A falling edge as input; only the line-two enable is set
    acc(1'b1, 2'h1, 1'b0, 8'h0C, v);
    @(posedge clk) l2_ext[0] <= 1'b0;
    acc(1'b1, 2'h1, 1'b1, 8'h00, v);
    acc(1'b1, 2'h1, 1'b1, 8'h00, v);
    check(v, 8'hCC);
    check({7'h00, a_int_oe}, 8'h01);
    @(posedge clk) l2_ext[0] <= 1'b1;
    // Side B line two as a rising-edge input
    acc(1'b1, 2'h3, 1'b0, 8'h1C, v);
    @(posedge clk) l2_ext[1] <= 1'b1;
    acc(1'b1, 2'h3, 1'b1, 8'h00, v);
    acc(1'b1, 2'h3, 1'b1, 8'h00, v);
    check(v, 8'h5C);
    check({6'h00, b_int, b_int_oe}, 8'h01);
    check({6'h00, l2_oe[1], l2_out[1]}, 8'h01);
    acc(1'b1, 2'h2, 1'b1, 8'h00, v);
    acc(1'b1, 2'h3, 1'b1, 8'h00, v);
    check(v, 8'h1C);
    // Read strobe on A line two, restored at the next phase-two fall
    acc(1'b1, 2'h1, 1'b0, 8'h2C, v);
    check({6'h00, l2_oe[0], l2_out[0]}, 8'h03);
    acc(1'b1, 2'h0, 1'b1, 8'h00, v);
    check({7'h00, l2_out[0]}, 8'h00);
    acc(1'b1, 2'h1, 1'b1, 8'h00, v);
    check({7'h00, l2_out[0]}, 8'h01);
    check(v, 8'h2C);
    // Manual level follows bit 3
    acc(1'b1, 2'h1, 1'b0, 8'h30, v);
    check({7'h00, l2_out[0]}, 8'h00);
    acc(1'b1, 2'h1, 1'b0, 8'h38, v);
    check({7'h00, l2_out[0]}, 8'h01);
    // Initialise pin clears everything again
    @(posedge clk) init_n <= 1'b0;
    repeat (4) @(posedge clk);
    init_n <= 1'b1;
    repeat (4) @(posedge clk);
    acc(1'b1, 2'h1, 1'b1, 8'h00, v);
    check(v, 8'h00);
    acc(1'b1, 2'h0, 1'b1, 8'h00, v);
    check(v, 8'h00);
    check(pb_oe, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
